//--- bench/serial_parallel_multiplier_tb.sv
`timescale 1ns/100ps
module serial_parallel_multiplier_tb import mult_pkg::*;;
  logic aclk, aresetn, ce, start, done, serial_ready, product_serial_out, sum_serial_out;
  logic operand_capture_n, mult_bit_in, addend_early_in;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] y_word, b_word, prod_bits, sum_bits, b;
  logic [31:0] seed, d;
  logic [7:0] x, y;
  logic [7:0] ys [3];
  int fail_count = 0, total_checks = 0, cycles = 0;

  serial_parallel_multiplier i_serial_parallel_multiplier (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .operand_capture_n, .mult_bit_in, .cascade_in(1'b0),
    .addend_in(1'b0), .addend_early_in, .serial_ready, .product_serial_out, .sum_serial_out,
    .cascade_out()
  );
  serial_source i_serial_source (
    .aclk, .aresetn, .start, .y_word, .b_word, .done, .prod_bits, .sum_bits, .serial_ready,
    .product_serial_out, .sum_serial_out, .operand_capture_n, .mult_bit_in, .addend_early_in
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs

  function automatic logic [15:0] exp_prod(input logic [7:0] a, input logic [7:0] m,
                                           input logic sgn);
    exp_prod = (sgn ? {{8{a[7]}}, a} : {8'h00, a}) * (sgn ? {{8{m[7]}}, m} : {8'h00, m});
  endfunction : exp_prod

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [4:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Valid lines are only seen after the first edge
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask : axi_write

  task automatic axi_read(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask : axi_read

  task automatic read_bytes(input logic [15:0] p);
    axi_read(RESULT_OFF);
    check("result low", {24'h0, p[7:0]}, d);
    axi_read(RESULT_OFF);
    check("result high", {24'h0, p[15:8]}, d);
  endtask : read_bytes

  task automatic start_job(input logic [7:0] m, input logic [15:0] a, input logic sgn);
    y_word <= sgn ? {{8{m[7]}}, m} : {8'h00, m};
    b_word <= a;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
  endtask : start_job

  task automatic end_job(input logic [7:0] a, input logic [7:0] m, input logic [15:0] ad,
                         input logic [1:0] c);
    logic [15:0] p;
    p = exp_prod(a, m, c[CTRL_SIGNED_BIT]);
    while (done !== 1'b1) @(posedge aclk);
    check("product", {16'h0, p}, {16'h0, prod_bits});
    check("sum", {16'h0, c[CTRL_ADD_BIT] ? p + ad : p - ad}, {16'h0, sum_bits});
  endtask : end_job

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {aresetn, start, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} <= 12'h000;
    {ce, s_axi_wdata, y_word, b_word, seed} <= {1'b1, 32'h0, 32'h0, 32'h73c6};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(CTRL_OFF);
    check("ctrl reset", {30'h0, CTRL_RESET}, d);
    axi_read(MCAND_OFF);
    check("mcand reset", {24'h0, MCAND_RESET}, d);
    axi_write(5'h14, 32'h1);
    check("write unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_read(5'h1c);
    check("read unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    check("read unmapped data", 32'h0, d);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {b, y, x} = seed;
      if (i < 2) begin
        x = i ? 8'h80 : 8'hff;
        y = x;
        b = 16'h0;
      end
      axi_write(CTRL_OFF, {30'h0, i[1:0]});
      axi_write(MCAND_OFF, {24'h0, x});
      check("write okay", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_read(MCAND_OFF);
      check("mcand", {24'h0, x}, d);
      start_job(y, b, i[0]);
      end_job(x, y, b, i[1:0]);
      read_bytes(exp_prod(x, y, i[0]));
    end
    $display("test products done");
    axi_write(CTRL_OFF, 32'h2);
    for (int j = 0; j < 3; j++) begin
      seed = xs(seed);
      ys[j] = seed[7:0];
      start_job(ys[j], 16'h0, 1'b0);
      if (j < 2) end_job(x, ys[j], 16'h0, 2'h2);
    end
    repeat (20) @(posedge aclk);
    check("stall ready", 32'h0, {31'h0, serial_ready});
    axi_read(STATUS_OFF);
    check("fifo count", FIFO_DEPTH, {29'h0, d[STATUS_COUNT_LSB +: 3]});
    for (int j = 0; j < 2; j++) read_bytes(exp_prod(x, ys[j], 1'b0));
    end_job(x, ys[2], 16'h0, 2'h2);
    read_bytes(exp_prod(x, ys[2], 1'b0));
    axi_read(RESULT_OFF);
    check("empty read", 32'h0, d);
    $display("test buffer done");
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    check("frozen ready", 32'h0, {31'h0, serial_ready});
    ce <= 1'b1;
    $display("test enable done");
    give_verdict();
  end
endmodule : serial_parallel_multiplier_tb

//--- bench/serial_source.sv
`timescale 1ns/100ps
module serial_source (
  // Clock, reset
  input wire logic aclk,
  input wire logic aresetn,
  // Job from the bench
  input wire logic start,
  input wire logic [15:0] y_word,
  input wire logic [15:0] b_word,
  output logic done,
  output logic [15:0] prod_bits,
  output logic [15:0] sum_bits,
  // Serial link
  input wire logic serial_ready,
  input wire logic product_serial_out,
  input wire logic sum_serial_out,
  output logic operand_capture_n,
  output logic mult_bit_in,
  output logic addend_early_in
);
  logic [15:0] y_reg;
  logic [15:0] b_reg;
  logic [4:0] step_reg;
  logic busy_reg;

  // Idle keeps the load asserted so no byte falls due
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      done <= 1'b0;
      operand_capture_n <= 1'b0;
      mult_bit_in <= 1'b0;
      addend_early_in <= 1'b0;
    end else if (start) begin
      y_reg <= y_word;
      b_reg <= b_word;
      mult_bit_in <= y_word[0];
      addend_early_in <= b_word[0];
      step_reg <= 5'h00;
      busy_reg <= 1'b1;
      done <= 1'b0;
    end else if (busy_reg && serial_ready) begin
      operand_capture_n <= step_reg != 5'h11;
      y_reg <= {y_reg[15], y_reg[15:1]};
      mult_bit_in <= y_reg[1];
      b_reg <= b_reg >> 1;
      addend_early_in <= b_reg[1];
      if (step_reg >= 5'h02) begin
        prod_bits <= {product_serial_out, prod_bits[15:1]};
        sum_bits <= {sum_serial_out, sum_bits[15:1]};
      end
      step_reg <= step_reg + 5'h01;
      busy_reg <= step_reg != 5'h11;
      done <= step_reg == 5'h11;
    end else if (!busy_reg) begin
      mult_bit_in <= ~mult_bit_in;
    end
  end
endmodule : serial_source

//--- bench/spm_checker.sv
`timescale 1ns/100ps
module spm_checker import mult_pkg::*; (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Serial side
  input wire logic operand_capture_n,
  input wire logic addend_in,
  input wire logic addend_early_in,
  input wire logic serial_ready,
  input wire logic product_serial_out,
  input wire logic sum_serial_out,
  input wire logic cascade_out
);
  logic clean_reg;
  logic armed_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // No addend bit since the last load, and past the load clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clean_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (serial_ready) begin
      clean_reg <= (clean_reg || !operand_capture_n) && !addend_in && !addend_early_in;
      armed_reg <= operand_capture_n;
    end
  end

  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  chk_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 5'h10
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_ce_freeze: assert property (!ce |-> !s_axi_awready && !s_axi_arready && !serial_ready)
    else $error("ready while clock enable low");
  chk_load_taken: assert property (!operand_capture_n && ce |-> serial_ready)
    else $error("load edge stalled");
  chk_stall_hold: assert property (!serial_ready |=> $stable(product_serial_out)
      && $stable(sum_serial_out))
    else $error("serial output moved while stalled");
  chk_cascade_copy: assert property (cascade_out == product_serial_out)
    else $error("cascade output differs from product");
  chk_sum_bare: assert property (armed_reg && clean_reg |-> sum_serial_out == product_serial_out)
    else $error("sum differs from product with zero addend");
endmodule : spm_checker

bind serial_parallel_multiplier spm_checker i_spm_checker (
  .aclk, .aresetn, .ce, .s_axi_awready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .operand_capture_n, .addend_in,
  .addend_early_in, .serial_ready, .product_serial_out, .sum_serial_out, .cascade_out
);

//--- rtl/byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo import mult_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Streams
  stream_if.snk in_s,
  stream_if.src out_s,
  // Fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_s.ready = (count_reg != DEPTH[PW:0]);
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem[rd_ptr_reg];
  assign push = ce & in_s.valid & in_s.ready;
  assign pop = ce & out_s.valid & out_s.ready;
  assign count = count_reg;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : byte_fifo

//--- rtl/mult_pkg.sv
package mult_pkg;
  localparam int OPERAND_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int FIFO_DEPTH = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 5'h00;
  localparam logic [ADDR_W-1:0] MCAND_OFF = 5'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 5'h08;
  localparam logic [ADDR_W-1:0] RESULT_OFF = 5'h0c;
  localparam int CTRL_SIGNED_BIT = 0;
  localparam int CTRL_ADD_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [OPERAND_W-1:0] MCAND_RESET = 8'h00;
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_RUN_BIT = 4;
  localparam int STATUS_BITCNT_LSB = 8;
  localparam logic [2:0] BITCNT_LAST = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic sum3(input logic a, input logic b, input logic c);
    sum3 = a ^ b ^ c;
  endfunction : sum3
endpackage : mult_pkg

//--- rtl/serial_addsub.sv
`timescale 1ns/100ps
module serial_addsub import mult_pkg::*; (
  // Clock, reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic add_sel,
  // Operand bits, LSB first
  input wire logic a_bit,
  input wire logic b_bit,
  // Result
  output logic sum_reg
);
  logic carry_reg;
  logic b_eff;

  // Subtract as a plus inverted b plus one
  assign b_eff = add_sel ? b_bit : ~b_bit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_reg <= 1'b0;
      sum_reg <= 1'b0;
    end else if (clear) begin
      carry_reg <= ~add_sel;
      sum_reg <= 1'b0;
    end else if (step) begin
      carry_reg <= maj3(a_bit, b_eff, carry_reg);
      sum_reg <= sum3(a_bit, b_eff, carry_reg);
    end
  end
endmodule : serial_addsub

//--- rtl/serial_parallel_multiplier.sv
`timescale 1ns/100ps
module serial_parallel_multiplier import mult_pkg::*; (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial operand side
  input wire logic operand_capture_n,
  input wire logic mult_bit_in,
  input wire logic cascade_in,
  input wire logic addend_in,
  input wire logic addend_early_in,
  output logic serial_ready,
  // Serial results
  output logic product_serial_out,
  output logic sum_serial_out,
  output logic cascade_out
);
  // Software registers
  logic [1:0] ctrl_reg;
  logic [OPERAND_W-1:0] mcand_reg;

  // Arithmetic array
  logic [OPERAND_W-1:0] mcand_hold_reg;
  logic mode_signed_reg;
  logic mult_bit_reg;
  logic [OPERAND_W-1:0] cell_sum_reg;
  logic [OPERAND_W-1:0] cell_carry_reg;
  logic ext_sum_reg;
  logic ext_carry_reg;
  logic [OPERAND_W-1:0] cell_sum_next;
  logic [OPERAND_W-1:0] cell_carry_next;
  logic ext_sum_next;
  logic ext_carry_next;
  logic [OPERAND_W-1:0] partial;
  logic top_in;
  logic addend_early_reg;
  run_state_t state_reg;

  // Byte packing of the product stream
  logic [OPERAND_W-1:0] pack_reg;
  logic [2:0] bitcnt_reg;
  logic load;
  logic push_want;
  logic take_load;
  logic take_run;
  logic [$clog2(FIFO_DEPTH):0] fifo_count;

  // AXI state
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic write_fire;
  logic ar_fire;
  logic [DATA_W-1:0] read_word;
  logic read_ok;

  stream_if #(.WIDTH(OPERAND_W)) fill_s ();
  stream_if #(.WIDTH(OPERAND_W)) drain_s ();

  assign load = ~operand_capture_n;
  assign push_want = (state_reg == ST_RUN) & ~load & (bitcnt_reg == BITCNT_LAST);
  // Full buffer stalls the array only when a byte is due
  assign take_load = ce & load;
  assign take_run = ce & ~load & (~push_want | fill_s.ready);
  assign serial_ready = take_load | take_run;

  // Top cell input: self-fed sign extension, or the upper slice
  assign top_in = mode_signed_reg ? ext_sum_reg : cascade_in;

  always_comb begin
    for (int i = 0; i < OPERAND_W; i++) begin
      partial[i] = mcand_hold_reg[i] & mult_bit_reg;
      cell_sum_next[i] = sum3(partial[i],
          (i == OPERAND_W - 1) ? top_in : cell_sum_reg[(i + 1) % OPERAND_W],
          cell_carry_reg[i]);
      cell_carry_next[i] = maj3(partial[i],
          (i == OPERAND_W - 1) ? top_in : cell_sum_reg[(i + 1) % OPERAND_W],
          cell_carry_reg[i]);
    end
    // One cell models the endless row of identical sign-extension cells
    ext_sum_next = sum3(partial[OPERAND_W-1], ext_sum_reg, ext_carry_reg);
    ext_carry_next = maj3(partial[OPERAND_W-1], ext_sum_reg, ext_carry_reg);
  end

  // Operand capture and multiplier shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcand_hold_reg <= '0;
      mode_signed_reg <= 1'b0;
      mult_bit_reg <= 1'b0;
    end else if (take_load) begin
      mcand_hold_reg <= mcand_reg;
      mode_signed_reg <= ctrl_reg[CTRL_SIGNED_BIT];
      mult_bit_reg <= mult_bit_in;
    end else if (take_run) begin
      mult_bit_reg <= mult_bit_in;
    end
  end

  // Arithmetic cells
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_sum_reg <= '0;
      cell_carry_reg <= '0;
      ext_sum_reg <= 1'b0;
      ext_carry_reg <= 1'b0;
    end else if (take_load) begin
      cell_sum_reg <= '0;
      cell_carry_reg <= '0;
      ext_sum_reg <= 1'b0;
      ext_carry_reg <= 1'b0;
    end else if (take_run) begin
      cell_sum_reg <= cell_sum_next;
      cell_carry_reg <= cell_carry_next;
      ext_sum_reg <= ext_sum_next;
      ext_carry_reg <= ext_carry_next;
    end
  end

  // Early addend delayed by one clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addend_early_reg <= 1'b0;
    end else if (take_load | take_run) begin
      addend_early_reg <= addend_early_in;
    end
  end

  // Run state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else if (take_load) begin
      state_reg <= ST_RUN;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Product bytes, LSB first, only after the load clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pack_reg <= '0;
      bitcnt_reg <= '0;
    end else if (take_load) begin
      pack_reg <= '0;
      bitcnt_reg <= '0;
    end else if (take_run && state_reg == ST_RUN) begin
      pack_reg <= {cell_sum_next[0], pack_reg[OPERAND_W-1:1]};
      bitcnt_reg <= bitcnt_reg + 1'b1;
    end
  end

  assign fill_s.valid = push_want;
  assign fill_s.data = {cell_sum_next[0], pack_reg[OPERAND_W-1:1]};

  byte_fifo #(.WIDTH(OPERAND_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_s(fill_s),
    .out_s(drain_s),
    .count(fifo_count)
  );

  // Direct addend or delayed early addend; partner drives one of them
  serial_addsub u_addsub (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(take_load),
    .step(take_run),
    .add_sel(ctrl_reg[CTRL_ADD_BIT]),
    .a_bit(cell_sum_next[0]),
    .b_bit(addend_in | addend_early_reg),
    .sum_reg(sum_serial_out)
  );

  assign product_serial_out = cell_sum_reg[0];
  assign cascade_out = cell_sum_reg[0];

  // AXI4-Lite write path
  assign s_axi_awready = ce & ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_have_reg & ~s_axi_bvalid;
  assign write_fire = ce & aw_have_reg & w_have_reg & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (write_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (write_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      mcand_reg <= MCAND_RESET;
    end else if (write_fire && wstrb_reg[0]) begin
      if ({awaddr_reg[ADDR_W-1:2], 2'b00} == CTRL_OFF) begin
        ctrl_reg <= wdata_reg[1:0];
      end
      if ({awaddr_reg[ADDR_W-1:2], 2'b00} == MCAND_OFF) begin
        mcand_reg <= wdata_reg[OPERAND_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg[ADDR_W-1:4] == '0) ? RESP_OKAY : RESP_SLVERR;
    end else if (ce && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  // Reading the result word pops one byte
  assign drain_s.ready = ar_fire &
      ({s_axi_araddr[ADDR_W-1:2], 2'b00} == RESULT_OFF);

  always_comb begin
    read_word = '0;
    read_ok = 1'b1;
    case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      CTRL_OFF: read_word[1:0] = ctrl_reg;
      MCAND_OFF: read_word[OPERAND_W-1:0] = mcand_reg;
      STATUS_OFF: begin
        read_word[STATUS_COUNT_LSB +: 3] = fifo_count;
        read_word[STATUS_RUN_BIT] = (state_reg == ST_RUN);
        read_word[STATUS_BITCNT_LSB +: 3] = bitcnt_reg;
      end
      RESULT_OFF: begin
        if (drain_s.valid) begin
          read_word[OPERAND_W-1:0] = drain_s.data;
        end
      end
      default: read_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (ce && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : serial_parallel_multiplier

//--- rtl/stream_if.sv
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
